// file: rpf_defs.svh
// Constants shared by the receive pause frame filter files.
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH

`define RPF_NUM_PRIO 9
`define RPF_GLOBAL_IDX 8
`define RPF_MCAST_BIT 40
`define RPF_BCAST_ADDR 48'hffff_ffff_ffff
`define RPF_ETYPE_MAC_CTRL 16'h8808
`define RPF_OP_GLOBAL_PAUSE 16'h0001
`define RPF_OP_PRIO_PAUSE 16'h0101
`define RPF_RST_QUANTA 16'h0000
`define RPF_RST_MASK9 9'h000

`endif

// file: rpf_pkg.sv
// Types for the receive pause frame filter.
package rpf_pkg;

  typedef logic [15:0] rpf_quanta_t;

  typedef logic [47:0] rpf_mac_addr_t;

  // Classification of the last frame summary, one-hot.
  typedef enum logic [4:0]
  {
    RPF_CLS_NONE = 5'b0_0001,
    RPF_CLS_GLOB_CTRL = 5'b0_0010,
    RPF_CLS_PRIO_CTRL = 5'b0_0100,
    RPF_CLS_GLOB_PAUSE = 5'b0_1000,
    RPF_CLS_PRIO_PAUSE = 5'b1_0000
  } rpf_class_t;

endpackage : rpf_pkg

// file: rpf_class_match.sv
// Match of one frame summary against the checks of one control frame class.
module rpf_class_match
(
  // Class configuration
  input wire logic class_enable,
  input wire logic chk_mcast,
  input wire logic chk_ucast,
  input wire logic chk_src,
  input wire logic chk_etype,
  input wire logic chk_opcode,
  input wire logic [15:0] cfg_etype,
  input wire logic [15:0] cfg_op_min,
  input wire logic [15:0] cfg_op_max,
  // Shared addresses
  input wire logic [47:0] cfg_unicast_dest_addr,
  input wire logic [47:0] cfg_multicast_dest_addr,
  input wire logic [47:0] cfg_source_addr,
  // Frame fields
  input wire logic [47:0] frm_dest,
  input wire logic [47:0] frm_src,
  input wire logic [15:0] frm_etype,
  input wire logic [15:0] frm_opcode,
  // Result
  output logic hit
);

  logic da_ok;
  logic sa_ok;
  logic et_ok;
  logic op_ok;

  // With both address checks on, either configured address is accepted.
  always_comb
  begin
    if (chk_mcast || chk_ucast)
    begin
      da_ok = (chk_mcast && (frm_dest == cfg_multicast_dest_addr)) ||
              (chk_ucast && (frm_dest == cfg_unicast_dest_addr));
    end
    else
    begin
      da_ok = 1'b1;
    end
  end

  assign sa_ok = !chk_src || (frm_src == cfg_source_addr);
  assign et_ok = !chk_etype || (frm_etype == cfg_etype);
  assign op_ok = !chk_opcode || ((frm_opcode >= cfg_op_min) && (frm_opcode <= cfg_op_max));
  assign hit = class_enable && da_ok && sa_ok && et_ok && op_ok;

endmodule : rpf_class_match

// file: rpf_filter.sv
// Receive pause frame filter: control frame classification, pause requests and statistics.
//
// Operation
// - Forward control frames only when forwarding is set
// - Acknowledge bus used only when waiting is enabled
// - Pause enable gates user-side pause outputs only
// - Global control class and its checks enabled
// - Global control opcode within inclusive min-max range
// - Unicast and source addresses compared with configuration
// - Multicast destination compared with configured address
// - Priority control class and its checks enabled
// - Priority control opcode within configured range
// - Global pause class and its checks enabled
// - Global pause opcode equals configured value
// - Priority pause class and its checks enabled
// - Priority pause opcode equals configured value
// - Each class compares its own ethertype
// - Strobes for unicast, multicast, broadcast, VLAN frames
// - Strobe for global pause with good check
// - Strobe for priority pause with good check
// - Strobe for length error with good check
// - Valid bus marks received quanta, global bit eight
// - Nine quanta outputs, global pause in entry eight
// - Pause request held until processing completes
`include "rpf_defs.svh"

module rpf_filter
#(
  parameter int NUM_PRIO = `RPF_NUM_PRIO
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Frame summary from the receive datapath, one pulse per frame end
  input wire logic frm_done,
  input wire logic frm_fcs_good,
  input wire logic frm_len_err,
  input wire logic frm_vlan,
  input wire logic [47:0] frm_dest,
  input wire logic [47:0] frm_src,
  input wire logic [15:0] frm_etype,
  input wire logic [15:0] frm_opcode,
  input wire logic [7:0] frm_prio_vector,
  input wire logic [NUM_PRIO-1:0][15:0] frm_quanta,
  // General configuration
  input wire logic cfg_forward_ctrl,
  input wire logic cfg_wait_ack,
  input wire logic [NUM_PRIO-1:0] cfg_pause_enable,
  input wire logic [47:0] cfg_unicast_dest_addr,
  input wire logic [47:0] cfg_multicast_dest_addr,
  input wire logic [47:0] cfg_source_addr,
  // Global control class configuration
  input wire logic cfg_glob_ctrl_enable,
  input wire logic glob_ctrl_mcast_match,
  input wire logic glob_ctrl_ucast_match,
  input wire logic glob_ctrl_src_match,
  input wire logic glob_ctrl_etype_match,
  input wire logic glob_ctrl_opcode_match,
  input wire logic [15:0] cfg_glob_ctrl_etype,
  input wire logic [15:0] cfg_glob_ctrl_op_min,
  input wire logic [15:0] cfg_glob_ctrl_op_max,
  // Priority control class configuration
  input wire logic cfg_prio_ctrl_enable,
  input wire logic prio_ctrl_mcast_match,
  input wire logic prio_ctrl_ucast_match,
  input wire logic prio_ctrl_src_match,
  input wire logic prio_ctrl_etype_match,
  input wire logic prio_ctrl_opcode_match,
  input wire logic [15:0] cfg_prio_ctrl_etype,
  input wire logic [15:0] cfg_prio_ctrl_op_min,
  input wire logic [15:0] cfg_prio_ctrl_op_max,
  // Global pause class configuration
  input wire logic cfg_glob_pause_enable,
  input wire logic glob_pause_mcast_match,
  input wire logic glob_pause_ucast_match,
  input wire logic glob_pause_src_match,
  input wire logic glob_pause_etype_match,
  input wire logic glob_pause_opcode_match,
  input wire logic [15:0] cfg_glob_pause_etype,
  input wire logic [15:0] cfg_glob_pause_opcode,
  // Priority pause class configuration
  input wire logic cfg_prio_pause_enable,
  input wire logic prio_pause_mcast_match,
  input wire logic prio_pause_ucast_match,
  input wire logic prio_pause_src_match,
  input wire logic prio_pause_etype_match,
  input wire logic prio_pause_opcode_match,
  input wire logic [15:0] cfg_prio_pause_etype,
  input wire logic [15:0] cfg_prio_pause_opcode,
  // User pause interface
  input wire logic [NUM_PRIO-1:0] pause_ack,
  output logic [NUM_PRIO-1:0] pause_valid_q,
  output logic [NUM_PRIO-1:0] pause_req_q,
  output logic [NUM_PRIO-1:0][15:0] pause_quanta_q,
  // Forwarding decision, one pulse per frame, and class held from the last frame
  output logic frm_forward_q,
  output logic frm_drop_q,
  output rpf_pkg::rpf_class_t frm_class_q,
  // Statistics strobes
  output logic stat_unicast_q,
  output logic stat_multicast_q,
  output logic stat_broadcast_q,
  output logic stat_vlan_q,
  output logic stat_pause_q,
  output logic stat_prio_pause_q,
  output logic stat_len_err_q
);

  logic glob_ctrl_hit;
  logic prio_ctrl_hit;
  logic glob_pause_hit;
  logic prio_pause_hit;
  logic is_ctrl;
  logic is_bcast;
  logic is_mcast;
  logic good;
  logic [NUM_PRIO-1:0] pause_set;
  logic [NUM_PRIO-1:0] pend_d;
  logic [NUM_PRIO-1:0] pend_q;
  rpf_pkg::rpf_class_t class_d;

  rpf_class_match u_glob_ctrl
  (
    .class_enable(cfg_glob_ctrl_enable),
    .chk_mcast(glob_ctrl_mcast_match),
    .chk_ucast(glob_ctrl_ucast_match),
    .chk_src(glob_ctrl_src_match),
    .chk_etype(glob_ctrl_etype_match),
    .chk_opcode(glob_ctrl_opcode_match),
    .cfg_etype(cfg_glob_ctrl_etype),
    .cfg_op_min(cfg_glob_ctrl_op_min),
    .cfg_op_max(cfg_glob_ctrl_op_max),
    .cfg_unicast_dest_addr(cfg_unicast_dest_addr),
    .cfg_multicast_dest_addr(cfg_multicast_dest_addr),
    .cfg_source_addr(cfg_source_addr),
    .frm_dest(frm_dest),
    .frm_src(frm_src),
    .frm_etype(frm_etype),
    .frm_opcode(frm_opcode),
    .hit(glob_ctrl_hit)
  );

  rpf_class_match u_prio_ctrl
  (
    .class_enable(cfg_prio_ctrl_enable),
    .chk_mcast(prio_ctrl_mcast_match),
    .chk_ucast(prio_ctrl_ucast_match),
    .chk_src(prio_ctrl_src_match),
    .chk_etype(prio_ctrl_etype_match),
    .chk_opcode(prio_ctrl_opcode_match),
    .cfg_etype(cfg_prio_ctrl_etype),
    .cfg_op_min(cfg_prio_ctrl_op_min),
    .cfg_op_max(cfg_prio_ctrl_op_max),
    .cfg_unicast_dest_addr(cfg_unicast_dest_addr),
    .cfg_multicast_dest_addr(cfg_multicast_dest_addr),
    .cfg_source_addr(cfg_source_addr),
    .frm_dest(frm_dest),
    .frm_src(frm_src),
    .frm_etype(frm_etype),
    .frm_opcode(frm_opcode),
    .hit(prio_ctrl_hit)
  );

  // A pause class is a range check whose bounds are the same opcode.
  rpf_class_match u_glob_pause
  (
    .class_enable(cfg_glob_pause_enable),
    .chk_mcast(glob_pause_mcast_match),
    .chk_ucast(glob_pause_ucast_match),
    .chk_src(glob_pause_src_match),
    .chk_etype(glob_pause_etype_match),
    .chk_opcode(glob_pause_opcode_match),
    .cfg_etype(cfg_glob_pause_etype),
    .cfg_op_min(cfg_glob_pause_opcode),
    .cfg_op_max(cfg_glob_pause_opcode),
    .cfg_unicast_dest_addr(cfg_unicast_dest_addr),
    .cfg_multicast_dest_addr(cfg_multicast_dest_addr),
    .cfg_source_addr(cfg_source_addr),
    .frm_dest(frm_dest),
    .frm_src(frm_src),
    .frm_etype(frm_etype),
    .frm_opcode(frm_opcode),
    .hit(glob_pause_hit)
  );

  rpf_class_match u_prio_pause
  (
    .class_enable(cfg_prio_pause_enable),
    .chk_mcast(prio_pause_mcast_match),
    .chk_ucast(prio_pause_ucast_match),
    .chk_src(prio_pause_src_match),
    .chk_etype(prio_pause_etype_match),
    .chk_opcode(prio_pause_opcode_match),
    .cfg_etype(cfg_prio_pause_etype),
    .cfg_op_min(cfg_prio_pause_opcode),
    .cfg_op_max(cfg_prio_pause_opcode),
    .cfg_unicast_dest_addr(cfg_unicast_dest_addr),
    .cfg_multicast_dest_addr(cfg_multicast_dest_addr),
    .cfg_source_addr(cfg_source_addr),
    .frm_dest(frm_dest),
    .frm_src(frm_src),
    .frm_etype(frm_etype),
    .frm_opcode(frm_opcode),
    .hit(prio_pause_hit)
  );

  assign good = frm_done && frm_fcs_good;
  assign is_bcast = (frm_dest == `RPF_BCAST_ADDR);
  assign is_mcast = frm_dest[`RPF_MCAST_BIT] && !is_bcast;
  assign is_ctrl = glob_ctrl_hit || prio_ctrl_hit || glob_pause_hit || prio_pause_hit;

  // Pause acts only on frames with a good check sequence; a global pause takes bit eight.
  always_comb
  begin
    pause_set = '0;
    if (good && prio_pause_hit)
    begin
      pause_set[7:0] = frm_prio_vector;
    end
    if (good && glob_pause_hit)
    begin
      pause_set[`RPF_GLOBAL_IDX] = 1'b1;
    end
  end

  // Pause priority order when classes overlap: pause first, then control.
  always_comb
  begin
    if (glob_pause_hit)
    begin
      class_d = rpf_pkg::RPF_CLS_GLOB_PAUSE;
    end
    else if (prio_pause_hit)
    begin
      class_d = rpf_pkg::RPF_CLS_PRIO_PAUSE;
    end
    else if (glob_ctrl_hit)
    begin
      class_d = rpf_pkg::RPF_CLS_GLOB_CTRL;
    end
    else if (prio_ctrl_hit)
    begin
      class_d = rpf_pkg::RPF_CLS_PRIO_CTRL;
    end
    else
    begin
      class_d = rpf_pkg::RPF_CLS_NONE;
    end
  end

  // Internal pause state is kept for every priority regardless of the user enable.
  always_comb
  begin
    pend_d = pend_q;
    if (cfg_wait_ack)
    begin
      pend_d = pend_q & ~pause_ack;
    end
    else
    begin
      pend_d = '0;
    end
    pend_d = pend_d | pause_set;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q <= `RPF_RST_MASK9;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // Without waiting the request lasts the one cycle of the valid pulse.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pause_req_q <= `RPF_RST_MASK9;
    end
    else
    begin
      pause_req_q <= pend_d & cfg_pause_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pause_valid_q <= `RPF_RST_MASK9;
    end
    else
    begin
      pause_valid_q <= pause_set & cfg_pause_enable;
    end
  end

  // Quanta hold their last value until a new pause of that priority arrives while its pause enable is set.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_PRIO; i++)
      begin
        pause_quanta_q[i] <= `RPF_RST_QUANTA;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_PRIO; i++)
      begin
        if (pause_set[i] && cfg_pause_enable[i])
        begin
          pause_quanta_q[i] <= frm_quanta[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      frm_forward_q <= 1'b0;
      frm_drop_q <= 1'b0;
      frm_class_q <= rpf_pkg::RPF_CLS_NONE;
    end
    else
    begin
      frm_forward_q <= frm_done && (!is_ctrl || cfg_forward_ctrl);
      frm_drop_q <= frm_done && is_ctrl && !cfg_forward_ctrl;
      if (frm_done)
      begin
        frm_class_q <= class_d;
      end
    end
  end

  // Statistics recognise the standard frames independently of the filter settings.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_unicast_q <= 1'b0;
      stat_multicast_q <= 1'b0;
      stat_broadcast_q <= 1'b0;
      stat_vlan_q <= 1'b0;
      stat_pause_q <= 1'b0;
      stat_prio_pause_q <= 1'b0;
      stat_len_err_q <= 1'b0;
    end
    else
    begin
      stat_unicast_q <= good && !frm_dest[`RPF_MCAST_BIT];
      stat_multicast_q <= good && is_mcast;
      stat_broadcast_q <= good && is_bcast;
      stat_vlan_q <= good && frm_vlan;
      stat_pause_q <= good && (frm_etype == `RPF_ETYPE_MAC_CTRL) &&
                      (frm_opcode == `RPF_OP_GLOBAL_PAUSE);
      stat_prio_pause_q <= good && (frm_etype == `RPF_ETYPE_MAC_CTRL) &&
                           (frm_opcode == `RPF_OP_PRIO_PAUSE);
      stat_len_err_q <= good && frm_len_err;
    end
  end

endmodule : rpf_filter

// file: rpf_props.sv
// Concurrent checks on the ports of the receive pause frame filter.
`include "rpf_defs.svh"
module rpf_props
#(
  parameter int NUM_PRIO = 9
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Frame summary and configuration
  input wire logic frm_done,
  input wire logic frm_fcs_good,
  input wire logic [15:0] frm_etype,
  input wire logic [15:0] frm_opcode,
  input wire logic [NUM_PRIO-1:0][15:0] frm_quanta,
  input wire logic cfg_wait_ack,
  input wire logic [NUM_PRIO-1:0] cfg_pause_enable,
  input wire logic [NUM_PRIO-1:0] pause_ack,
  // Filter outputs
  input wire logic [NUM_PRIO-1:0] pause_valid_q,
  input wire logic [NUM_PRIO-1:0] pause_req_q,
  input wire logic [NUM_PRIO-1:0][15:0] pause_quanta_q,
  input wire logic frm_forward_q,
  input wire logic frm_drop_q,
  input wire logic stat_pause_q,
  input wire logic stat_prio_pause_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic good_ctrl;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  assign good_ctrl = frm_done && frm_fcs_good && frm_etype == `RPF_ETYPE_MAC_CTRL;

  // A global request waiting on the user, and the user answering it.
  sequence s_glob_waiting;
    cfg_wait_ack && cfg_pause_enable[8] && pause_req_q[8];
  endsequence
  sequence s_glob_acked;
    s_glob_waiting ##0 (pause_ack[8] && !frm_done);
  endsequence

  a_fwd_drop_pulse: assert property ((frm_forward_q || frm_drop_q) == $past(frm_done))
    else $error("forward or drop pulse count wrong");
  a_pause_stat: assert property (stat_pause_q ==
    ($past(good_ctrl) && $past(frm_opcode) == `RPF_OP_GLOBAL_PAUSE))
    else $error("pause strobe wrong");
  a_prio_stat: assert property (stat_prio_pause_q ==
    ($past(good_ctrl) && $past(frm_opcode) == `RPF_OP_PRIO_PAUSE))
    else $error("priority pause strobe wrong");
  a_valid_gated: assert property ((pause_valid_q & ~$past(cfg_pause_enable)) == '0)
    else $error("valid on a disabled priority");
  a_req_nowait: assert property (!cfg_wait_ack && !$past(cfg_wait_ack) |->
    pause_req_q == pause_valid_q)
    else $error("request outlives valid without waiting");
  a_req_hold: assert property (s_glob_waiting ##0 !pause_ack[8] |=> pause_req_q[8])
    else $error("request dropped before acknowledge");
  a_ack_clear: assert property (s_glob_acked |=> !pause_req_q[8])
    else $error("request not cleared after acknowledge");
  a_quanta_glob: assert property (pause_valid_q[8] |->
    pause_quanta_q[8] == $past(frm_quanta[8]))
    else $error("global quanta wrong");
endmodule : rpf_props

bind rpf_filter rpf_props #(.NUM_PRIO(NUM_PRIO)) rpf_props_i (.*);

// file: rpf_user_model.sv
// Behavioural user logic that acknowledges pause requests after a set delay.
module rpf_user_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pause requests in, acknowledge out
  input wire logic [3:0] ack_delay,
  input wire logic [8:0] pause_req_q,
  output logic [8:0] pause_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // The acknowledge is a one-cycle copy of the pending requests, so it never lingers unless ack_delay is zero.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_q <= 4'h0;
      pause_ack <= 9'h000;
    end
    else if (pause_req_q == 9'h000 || wait_q == ack_delay)
    begin
      wait_q <= 4'h0;
      pause_ack <= (wait_q == ack_delay) ? pause_req_q : 9'h000;
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
      pause_ack <= 9'h000;
    end
  end
endmodule : rpf_user_model

// file: tb.sv
// Self-checking testbench for the receive pause frame filter.
`include "rpf_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] MC = 48'h0180_c200_0001;
  localparam logic [47:0] UC = 48'h0200_0000_00aa;
  localparam logic [47:0] SA = 48'h0200_0000_0055;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic frm_done = 1'b0;
  logic frm_fcs_good, frm_len_err, frm_vlan, cfg_forward_ctrl, cfg_wait_ack, frm_forward_q;
  logic frm_drop_q, stat_unicast_q, stat_multicast_q, stat_broadcast_q, stat_vlan_q;
  logic stat_pause_q, stat_prio_pause_q, stat_len_err_q;
  logic [47:0] frm_dest, frm_src, cfg_unicast_dest_addr, cfg_multicast_dest_addr, cfg_source_addr;
  logic [15:0] frm_etype, frm_opcode, cfg_glob_pause_opcode, cfg_prio_pause_opcode;
  logic [15:0] cfg_glob_ctrl_etype, cfg_prio_ctrl_etype, cfg_glob_pause_etype, cfg_prio_pause_etype;
  logic [15:0] cfg_glob_ctrl_op_min, cfg_glob_ctrl_op_max, cfg_prio_ctrl_op_min, cfg_prio_ctrl_op_max;
  logic [7:0] frm_prio_vector;
  logic [8:0][15:0] frm_quanta, pause_quanta_q;
  logic [8:0] cfg_pause_enable, pause_ack, pause_valid_q, pause_req_q;
  logic [4:0] gc, pc, gp, pp;
  logic [3:0] cls_en, ack_delay;
  logic [15:0] ofs [4] = '{16'hffff, 16'h0000, 16'h0010, 16'h0011};
  rpf_pkg::rpf_class_t frm_class_q;
  int checks = 0;
  int err_count = 0;
  int n;

  rpf_filter rpf_filter_i
  (
    .*,
    .cfg_glob_ctrl_enable(cls_en[0]), .cfg_prio_ctrl_enable(cls_en[1]),
    .cfg_glob_pause_enable(cls_en[2]), .cfg_prio_pause_enable(cls_en[3]),
    .glob_ctrl_mcast_match(gc[4]), .glob_ctrl_ucast_match(gc[3]), .glob_ctrl_src_match(gc[2]),
    .glob_ctrl_etype_match(gc[1]), .glob_ctrl_opcode_match(gc[0]),
    .prio_ctrl_mcast_match(pc[4]), .prio_ctrl_ucast_match(pc[3]), .prio_ctrl_src_match(pc[2]),
    .prio_ctrl_etype_match(pc[1]), .prio_ctrl_opcode_match(pc[0]),
    .glob_pause_mcast_match(gp[4]), .glob_pause_ucast_match(gp[3]),
    .glob_pause_src_match(gp[2]), .glob_pause_etype_match(gp[1]),
    .glob_pause_opcode_match(gp[0]), .prio_pause_mcast_match(pp[4]),
    .prio_pause_ucast_match(pp[3]), .prio_pause_src_match(pp[2]),
    .prio_pause_etype_match(pp[1]), .prio_pause_opcode_match(pp[0])
  );
  rpf_user_model rpf_user_model_i (.*);

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits a falling edge first, so frm_done is never set and cleared in one step.
  task automatic frame(input logic [47:0] d, input logic [15:0] e, input logic [15:0] o);
    @(negedge clk_sys);
    {frm_dest, frm_etype, frm_opcode, frm_done} = {d, e, o, 1'b1};
    @(negedge clk_sys);
    frm_done = 1'b0;
  endtask : frame

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial
  begin
    {frm_fcs_good, frm_len_err, frm_vlan, cfg_wait_ack, frm_prio_vector, frm_quanta} = '0;
    {gc, pc, gp, pp, cls_en, ack_delay, frm_dest, frm_etype, frm_opcode} = '0;
    {cfg_forward_ctrl, cfg_pause_enable, frm_src} = {1'b0, 9'h1f7, SA};
    {cfg_unicast_dest_addr, cfg_multicast_dest_addr, cfg_source_addr} = {UC, MC, SA};
    {cfg_glob_ctrl_etype, cfg_prio_ctrl_etype, cfg_glob_pause_etype, cfg_prio_pause_etype} =
      {4{`RPF_ETYPE_MAC_CTRL}};
    {cfg_glob_ctrl_op_min, cfg_glob_ctrl_op_max, cfg_prio_ctrl_op_min, cfg_prio_ctrl_op_max} =
      64'h0010_0020_0030_0040;
    {cfg_glob_pause_opcode, cfg_prio_pause_opcode} = {`RPF_OP_GLOBAL_PAUSE, `RPF_OP_PRIO_PAUSE};
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    {frm_fcs_good, cfg_wait_ack, ack_delay, cls_en, gp, frm_quanta[8]} =
      {2'b11, 4'h3, 4'h4, 5'h1f, 16'h1234};
    frame(MC, `RPF_ETYPE_MAC_CTRL, `RPF_OP_GLOBAL_PAUSE);
    chk({frm_drop_q, frm_forward_q, stat_pause_q, stat_multicast_q}, 4'hb);
    chk({pause_valid_q, pause_quanta_q[8]}, {9'h100, 16'h1234});
    chk(frm_class_q, rpf_pkg::RPF_CLS_GLOB_PAUSE);
    n = 0;
    while (pause_req_q[8] === 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, ack_delay + 2);
    if (n == 20)
      results();
    // Each check refuses its bad field while on and lets it through when off.
    cfg_wait_ack = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      gp = 5'h1f;
      frm_src = (i == 1) ? UC : SA;
      repeat (2)
      begin
        frame((i == 0) ? UC + 48'h1 : MC, `RPF_ETYPE_MAC_CTRL ^ {15'h0, i == 2},
          `RPF_OP_GLOBAL_PAUSE ^ {14'h0, i == 3, 1'b0});
        chk(pause_valid_q, (gp == 5'h1f) ? 9'h000 : 9'h100);
        gp = (i == 0) ? 5'h07 : gp & ~(5'h08 >> i);
      end
      @(negedge clk_sys);
      chk(pause_req_q, 9'h000);
    end
    {cls_en, pp, frm_prio_vector, frm_quanta[0], cfg_wait_ack} =
      {4'h8, 5'h0f, 8'h09, 16'h00aa, 1'b1};
    frame(UC, `RPF_ETYPE_MAC_CTRL, `RPF_OP_PRIO_PAUSE);
    chk({pause_valid_q, stat_prio_pause_q, stat_unicast_q}, 11'h007);
    chk(pause_quanta_q[0], 16'h00aa);
    chk(frm_class_q, rpf_pkg::RPF_CLS_PRIO_PAUSE);
    // The masked priority stays pending inside, so enabling it exposes the request.
    cfg_pause_enable = 9'h1ff;
    @(negedge clk_sys);
    chk(pause_req_q, 9'h009);
    {gc, pc} = {5'h01, 5'h01};
    for (int k = 0; k < 8; k++)
    begin
      cls_en = (k < 4) ? 4'h1 : 4'h2;
      frame(MC, `RPF_ETYPE_MAC_CTRL, ((k < 4) ? 16'h0010 : 16'h0030) + ofs[k % 4]);
      chk(frm_drop_q, k[1] ^ k[0]);
      chk(frm_class_q, !(k[1] ^ k[0]) ? rpf_pkg::RPF_CLS_NONE :
        (k < 4) ? rpf_pkg::RPF_CLS_GLOB_CTRL : rpf_pkg::RPF_CLS_PRIO_CTRL);
    end
    {cls_en, frm_len_err, frm_vlan, cfg_forward_ctrl} = {4'h0, 3'b111};
    frame(`RPF_BCAST_ADDR, 16'h0800, 16'h0000);
    chk({stat_broadcast_q, stat_vlan_q, stat_len_err_q, frm_forward_q}, 4'hf);
    frm_fcs_good = 1'b0;
    frame(`RPF_BCAST_ADDR, 16'h0800, 16'h0000);
    chk({stat_broadcast_q, stat_vlan_q, stat_len_err_q, frm_forward_q}, 4'h1);
    cls_en = 4'h1;
    frame(MC, `RPF_ETYPE_MAC_CTRL, 16'h0010);
    chk({frm_drop_q, frm_forward_q, frm_class_q}, {2'b01, rpf_pkg::RPF_CLS_GLOB_CTRL});
    results();
  end
endmodule : tb
